/* cmap_cache.sv */
// Direct-mapped cache with two-word line fill and duplicate snoop tags.
`timescale 1ns/100ps
module cmap_cache import cmap_pkg::*; #(
  parameter int LINES = CACHE_LINES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  cmap_if.cache cif,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic dma_busy,
  input wire logic dma_wr,
  input wire logic [ADDR_W-1:0] dma_addr
);
  localparam int IW = $clog2(LINES);
  localparam int TW = ADDR_W - 2 - IW;
  typedef enum logic [1:0] {C_IDLE, C_FILL0, C_FILL1, C_WRITE} cmap_cst_e;

  function automatic logic [IW-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[2 +: IW];
  endfunction
  function automatic logic [TW-1:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: TW];
  endfunction

  cmap_cst_e cst_ff;
  logic [LINES-1:0] valid_ff;
  logic [TW-1:0] ptag_ff [LINES];
  logic [TW-1:0] dtag_ff [LINES];
  logic [DATA_W-1:0] data_ff [LINES][2];
  logic [ADDR_W-1:0] req_addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic rdy_ff;
  logic stale_ff;
  logic [ADDR_W-1:0] mem_addr_ff;

  wire [IW-1:0] ridx = idx_of(cif.addr);
  wire [IW-1:0] fidx = idx_of(req_addr_ff);
  wire [IW-1:0] sidx = idx_of(dma_addr);
  wire hit = valid_ff[ridx] && ptag_ff[ridx] == tag_of(cif.addr);
  wire snoop_hit = dma_wr && valid_ff[sidx] && dtag_ff[sidx] == tag_of(dma_addr);
  wire snoop_fill = dma_wr && sidx == fidx && tag_of(dma_addr) == tag_of(req_addr_ff);
  wire accept = cst_ff == C_IDLE && cif.req && !rdy_ff && !snoop_hit;
  wire fill0_ack = cst_ff == C_FILL0 && mem_ack;
  wire fill1_ack = cst_ff == C_FILL1 && mem_ack;
  wire write_ack = cst_ff == C_WRITE && mem_ack;
  wire wr_hit = valid_ff[fidx] && ptag_ff[fidx] == tag_of(req_addr_ff);

  assign mem_req = cst_ff != C_IDLE && !dma_busy; // [RULE7]
  assign mem_we = cst_ff == C_WRITE;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = wdata_ff;
  assign cif.ready = rdy_ff;
  assign cif.rdata = rdata_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cst_ff <= C_IDLE;
      valid_ff <= '0;
      req_addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      rdy_ff <= 1'b0;
      stale_ff <= 1'b0;
      mem_addr_ff <= '0;
    end else begin
      rdy_ff <= (accept && !cif.we && hit) || fill1_ack || write_ack; // [RULE1]
      if (accept) begin
        req_addr_ff <= cif.addr;
        wdata_ff <= cif.wdata;
        stale_ff <= 1'b0;
        mem_addr_ff <= cif.we ? cif.addr : {cif.addr[ADDR_W-1:2], 2'b00};
        if (cif.we) begin
          cst_ff <= C_WRITE;
        end else if (hit) begin
          rdata_ff <= data_ff[ridx][cif.addr[1]]; // [RULE8]
        end else begin
          cst_ff <= C_FILL0; // [RULE1]
        end
      end
      if (snoop_fill) begin
        stale_ff <= 1'b1;
      end
      if (fill0_ack) begin
        mem_addr_ff <= {req_addr_ff[ADDR_W-1:2], 2'b10}; // [RULE2]
        cst_ff <= C_FILL1;
      end
      if (fill1_ack) begin
        rdata_ff <= req_addr_ff[1] ? mem_rdata : data_ff[fidx][0];
        cst_ff <= C_IDLE;
        if (!stale_ff && !snoop_fill) begin
          valid_ff[fidx] <= 1'b1; // [RULE2]
        end
      end
      if (write_ack) begin
        cst_ff <= C_IDLE;
      end
      if (snoop_hit) begin
        valid_ff[sidx] <= 1'b0; // [RULE8]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (fill0_ack) begin
      data_ff[fidx][0] <= mem_rdata;
    end
    if (fill1_ack) begin
      data_ff[fidx][1] <= mem_rdata; // [RULE2]
      ptag_ff[fidx] <= tag_of(req_addr_ff);
      dtag_ff[fidx] <= tag_of(req_addr_ff);
    end
    if (write_ack && wr_hit) begin
      data_ff[fidx][req_addr_ff[1]] <= wdata_ff;
    end
  end

  AST_MEM_WAITS_DMA: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE7]
    dma_busy |-> !mem_req) else $error("Memory request issued during DMA.");
  AST_PAIR_FILL: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2]
    fill0_ack |=> cst_ff == C_FILL1 && mem_addr[1] && !mem_we) else $error("Second fill word not requested.");
  AST_HIT_NEXT: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE1]
    accept && !cif.we && hit |=> cif.ready && cst_ff == C_IDLE) else $error("Cache hit not answered next cycle.");
  AST_SNOOP_KILL: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE8]
    snoop_hit |=> !valid_ff[$past(sidx)]) else $error("Snooped line still valid.");
  COV_FILL: cover property (@(posedge sys_clk) disable iff (!resetn) fill1_ack);
  COV_HIT_DMA: cover property (@(posedge sys_clk) disable iff (!resetn) accept && hit && dma_busy);
endmodule

/* cmap_if.sv */
// Request port between the access sequencer and the cache.
`timescale 1ns/100ps
interface cmap_if import cmap_pkg::*; ();
  logic req;
  logic we;
  logic ready;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport core(output req, output we, output addr, output wdata, input ready, input rdata);
  modport cache(input req, input we, input addr, input wdata, output ready, output rdata);
endinterface

/* cmap_mem_model.sv */
// Behavioural main memory on the shared bus, answering after a settable delay.
`timescale 1ns/100ps
module cmap_mem_model import cmap_pkg::*; (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  output logic mem_ack,
  output logic [DATA_W-1:0] mem_rdata
);
  logic [DATA_W-1:0] mem [0:255];
  logic [ADDR_W-1:0] rd_log [$];
  logic [ADDR_W-1:0] wa_log [$];
  logic [DATA_W-1:0] wd_log [$];
  int lat = 0;
  int cnt = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // Outside an answer the data lines invert every cycle, so the old word shows again on every second cycle.
  always @(posedge sys_clk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= 0;
    end else if (mem_req === 1'b1 && cnt >= lat) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        mem[mem_addr[8:1]] <= mem_wdata;
        wa_log.push_back(mem_addr);
        wd_log.push_back(mem_wdata);
      end else begin
        mem_rdata <= mem[mem_addr[8:1]];
        rd_log.push_back(mem_addr);
      end
    end else begin
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req === 1'b1) ? cnt + 1 : 0;
    end
  end
endmodule

/* cmap_pkg.sv */
// Shared constants for the processor memory access path.
package cmap_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MICROCYCLE_NS = 222;
  localparam int UCYC_CYCLES = (MICROCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CACHE_LINES = 16;
  localparam logic [3:0] OPC_COPY = 4'h1;
  localparam logic [9:0] OPC_INC = 10'h02a;
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_DEF = 3'h1;
  localparam logic [2:0] MODE_AINC = 3'h2;
  localparam logic [2:0] MODE_AINC_DEF = 3'h3;
  localparam logic [2:0] MODE_ADEC = 3'h4;
  localparam logic [2:0] MODE_ADEC_DEF = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] PC_IDX = 3'h7;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] INC_STEP = 16'h0001;
  localparam logic [15:0] RESET_PC = 16'h0000;
endpackage

/* cmap_top.sv */
// Processor memory access path: sequencer, instruction buffer and cache.
// Overview of operation
// RULE1 - Reads hit in cache are served there; misses go to memory automatically.
// RULE2 - Every main-memory read fills a pair of words into the cache.
// RULE3 - Prefetcher fetches next sequential instruction word in idle cycles into buffer.
// RULE4 - A wrong buffered word is discarded and the processor stalls for the real one.
// RULE5 - Reads through the program counter are instruction stream; others are never predicted.
// RULE6 - The processor microcycle is 222 ns from the crystal clock; the code rounds it up to 3 clocks of 100 ns, 300 ns.
// RULE7 - Memory reads or writes wait while a DMA transfer holds the bus.
// RULE8 - Duplicate tags keep hits going under DMA; DMA writes invalidate held lines.
// RULE9 - Every instruction starts with an opcode fetch giving mode and register fields.
// RULE10 - Increment of a register operand completes without memory operand access.
// RULE11 - Memory increment resolves address, reads, adds one, writes back same address.
// RULE12 - Copy instruction decodes a source and a destination mode-register field.
// RULE13 - Copy evaluates source address, destination address, reads source, writes destination.
`timescale 1ns/100ps
module cmap_top import cmap_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic dma_busy,
  input wire logic dma_wr,
  input wire logic [ADDR_W-1:0] dma_addr,
  output logic instr_done,
  output logic cpu_stall,
  output logic [DATA_W-1:0] pc_value
);
  typedef enum logic [2:0] {S_FETCH, S_DECODE, S_EA, S_IDX, S_IND, S_OPRD, S_WR} cmap_st_e;
  localparam logic [1:0] UCYC_LAST = 2'(UCYC_CYCLES - 1);

  cmap_if cif();
  cmap_st_e st_ff, nxt_st;
  logic [DATA_W-1:0] regs_ff [8];
  logic [DATA_W-1:0] ir_ff, mdr_ff, opnd_ff, nxt_opnd;
  logic [ADDR_W-1:0] ea_ff, nxt_ea, src_ea_ff, rd_addr_ff;
  logic ea_pc_ff, nxt_ea_pc, src_pc_ff, dst_ph_ff, nxt_dst, got_ff, done_ff;
  logic [1:0] ucyc_ff;
  logic ibuf_valid_ff, pf_busy_ff;
  logic [ADDR_W-1:0] ibuf_addr_ff, pf_addr_ff;
  logic [DATA_W-1:0] ibuf_data_ff;
  logic acc_need, acc_we, acc_istr, rf_we, ea_fin, fin;
  logic [ADDR_W-1:0] acc_addr;
  logic [2:0] rf_idx;
  logic [DATA_W-1:0] rf_wd;

  wire [DATA_W-1:0] pc = regs_ff[PC_IDX];
  wire [2:0] smode = ir_ff[11:9];
  wire [2:0] sreg = ir_ff[8:6];
  wire [2:0] dmode = ir_ff[5:3];
  wire [2:0] dreg = ir_ff[2:0];
  wire is_copy = ir_ff[15:12] == OPC_COPY; // [RULE12]
  wire is_inc = ir_ff[15:6] == OPC_INC;
  wire [2:0] cur_mode = dst_ph_ff ? dmode : smode;
  wire [2:0] cur_reg = dst_ph_ff ? dreg : sreg;
  wire [DATA_W-1:0] cur_r = regs_ff[cur_reg];
  wire [2:0] rd_mode = is_copy ? smode : dmode;
  wire tick = ucyc_ff == UCYC_LAST; // [RULE6]
  wire acc_req = acc_need && !got_ff;
  wire adv = tick && (!acc_need || got_ff);
  wire ibuf_hit = ibuf_valid_ff && ibuf_addr_ff == acc_addr;
  wire ibuf_use = acc_req && acc_istr && ibuf_hit; // [RULE5]
  wire seq_cache = acc_req && !ibuf_use;
  wire pf_want = !(ibuf_valid_ff && ibuf_addr_ff == pc);
  wire sel_pf = pf_busy_ff || (!seq_cache && pf_want); // [RULE3]
  wire [ADDR_W-1:0] pf_a = pf_busy_ff ? pf_addr_ff : pc;
  wire pf_done = sel_pf && cif.ready;
  wire acc_done = ibuf_use || (seq_cache && cif.ready && !sel_pf);
  wire [DATA_W-1:0] acc_data = ibuf_use ? ibuf_data_ff : cif.rdata;
  wire ibuf_kill = (acc_req && acc_we && acc_addr == ibuf_addr_ff) || (dma_wr && dma_addr == ibuf_addr_ff);

  assign cif.req = sel_pf || seq_cache;
  assign cif.we = !sel_pf && acc_we;
  assign cif.addr = sel_pf ? pf_a : acc_addr;
  assign cif.wdata = opnd_ff;
  assign instr_done = done_ff;
  assign cpu_stall = acc_req; // [RULE4]
  assign pc_value = pc;

  cmap_cache #(.LINES(CACHE_LINES)) u_cache (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cif(cif),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .dma_busy(dma_busy),
    .dma_wr(dma_wr),
    .dma_addr(dma_addr)
  );

  always_comb begin
    nxt_st = st_ff;
    acc_need = 1'b0;
    acc_we = 1'b0;
    acc_istr = 1'b0;
    acc_addr = pc;
    rf_we = 1'b0;
    rf_idx = cur_reg;
    rf_wd = cur_r;
    nxt_ea = ea_ff;
    nxt_ea_pc = ea_pc_ff;
    nxt_dst = dst_ph_ff;
    nxt_opnd = opnd_ff;
    ea_fin = 1'b0;
    fin = 1'b0;
    case (st_ff)
      S_FETCH: begin
        acc_need = 1'b1; // [RULE9]
        acc_istr = 1'b1;
        if (adv) begin
          rf_we = 1'b1;
          rf_idx = PC_IDX;
          rf_wd = pc + WORD_STEP;
          nxt_st = S_DECODE;
        end
      end
      S_DECODE: begin
        if (adv) begin
          nxt_dst = is_inc;
          nxt_st = S_EA;
          if (is_inc && dmode == MODE_REG) begin
            rf_we = 1'b1; // [RULE10]
            rf_idx = dreg;
            rf_wd = regs_ff[dreg] + INC_STEP;
            fin = 1'b1;
            nxt_st = S_FETCH;
          end else if (!is_inc && !is_copy) begin
            fin = 1'b1;
            nxt_st = S_FETCH;
          end
        end
      end
      S_EA: begin
        if (adv) begin
          nxt_ea_pc = cur_reg == PC_IDX && (cur_mode == MODE_AINC || cur_mode == MODE_AINC_DEF); // [RULE5]
          case (cur_mode)
            MODE_REG, MODE_DEF: begin
              nxt_ea = cur_r;
              ea_fin = 1'b1;
            end
            MODE_AINC, MODE_AINC_DEF: begin
              nxt_ea = cur_r;
              rf_we = 1'b1;
              rf_wd = cur_r + WORD_STEP;
              ea_fin = cur_mode == MODE_AINC;
              nxt_st = S_IND;
            end
            MODE_ADEC, MODE_ADEC_DEF: begin
              nxt_ea = cur_r - WORD_STEP;
              rf_we = 1'b1;
              rf_wd = cur_r - WORD_STEP;
              ea_fin = cur_mode == MODE_ADEC;
              nxt_st = S_IND;
            end
            default: nxt_st = S_IDX;
          endcase
        end
      end
      S_IDX: begin
        acc_need = 1'b1;
        acc_istr = 1'b1;
        if (adv) begin
          rf_we = 1'b1;
          rf_idx = PC_IDX;
          rf_wd = pc + WORD_STEP;
          nxt_ea = mdr_ff + (cur_reg == PC_IDX ? pc + WORD_STEP : cur_r); // [RULE11]
          nxt_ea_pc = 1'b0;
          ea_fin = cur_mode == MODE_IDX;
          nxt_st = S_IND;
        end
      end
      S_IND: begin
        acc_need = 1'b1;
        acc_istr = ea_pc_ff;
        acc_addr = ea_ff;
        if (adv) begin
          nxt_ea = mdr_ff;
          nxt_ea_pc = 1'b0;
          ea_fin = 1'b1;
        end
      end
      S_OPRD: begin
        acc_need = rd_mode != MODE_REG;
        acc_istr = is_copy ? src_pc_ff : ea_pc_ff;
        acc_addr = is_copy ? src_ea_ff : ea_ff; // [RULE13]
        if (adv) begin
          nxt_opnd = rd_mode == MODE_REG ? regs_ff[sreg] : mdr_ff;
          if (is_inc) begin
            nxt_opnd = mdr_ff + INC_STEP; // [RULE11]
          end
          nxt_st = S_WR;
        end
      end
      S_WR: begin
        acc_need = dmode != MODE_REG;
        acc_we = 1'b1;
        acc_addr = ea_ff; // [RULE11]
        if (adv) begin
          rf_we = dmode == MODE_REG;
          rf_idx = dreg;
          rf_wd = opnd_ff;
          fin = 1'b1;
          nxt_st = S_FETCH;
        end
      end
      default: nxt_st = S_FETCH;
    endcase
    if (ea_fin) begin
      nxt_st = S_OPRD;
      if (is_copy && !dst_ph_ff) begin
        nxt_dst = 1'b1; // [RULE13]
        nxt_st = S_EA;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        regs_ff[i] <= (i == 7) ? RESET_PC : '0;
      end
      st_ff <= S_FETCH;
      ir_ff <= '0;
      mdr_ff <= '0;
      opnd_ff <= '0;
      ea_ff <= '0;
      ea_pc_ff <= 1'b0;
      src_ea_ff <= '0;
      src_pc_ff <= 1'b0;
      rd_addr_ff <= '0;
      dst_ph_ff <= 1'b0;
      got_ff <= 1'b0;
      done_ff <= 1'b0;
      ucyc_ff <= '0;
    end else begin
      ucyc_ff <= tick ? '0 : ucyc_ff + 2'h1;
      got_ff <= adv ? 1'b0 : (got_ff || acc_done);
      if (acc_done) begin
        mdr_ff <= acc_data;
      end
      if (st_ff == S_OPRD && acc_done) begin
        rd_addr_ff <= acc_addr;
      end
      if (adv && st_ff == S_FETCH) begin
        ir_ff <= mdr_ff;
      end
      if (ea_fin && is_copy && !dst_ph_ff) begin
        src_ea_ff <= nxt_ea;
        src_pc_ff <= nxt_ea_pc;
      end
      if (rf_we) begin
        regs_ff[rf_idx] <= rf_wd;
      end
      st_ff <= nxt_st; // [RULE6]
      ea_ff <= nxt_ea;
      ea_pc_ff <= nxt_ea_pc;
      dst_ph_ff <= nxt_dst;
      opnd_ff <= nxt_opnd;
      done_ff <= fin;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ibuf_valid_ff <= 1'b0;
      ibuf_addr_ff <= '0;
      ibuf_data_ff <= '0;
      pf_busy_ff <= 1'b0;
      pf_addr_ff <= '0;
    end else begin
      pf_busy_ff <= sel_pf && !cif.ready;
      pf_addr_ff <= pf_a;
      if (pf_done) begin
        ibuf_valid_ff <= 1'b1; // [RULE3]
        ibuf_addr_ff <= pf_a;
        ibuf_data_ff <= cif.rdata;
      end else if ((acc_req && acc_istr && !ibuf_hit) || ibuf_use || ibuf_kill) begin
        ibuf_valid_ff <= 1'b0; // [RULE4]
      end
    end
  end

  AST_MICROCYCLE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE6]
    st_ff != $past(st_ff) |-> $past(ucyc_ff) == UCYC_LAST) else $error("State moved off a microcycle edge.");
  AST_IBUF_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE3]
    acc_req && acc_istr && ibuf_hit |-> acc_done && !cif.req || sel_pf) else $error("Buffered word not used.");
  AST_DISCARD: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE4]
    acc_req && acc_istr && !ibuf_hit && !pf_done |=> !ibuf_valid_ff) else $error("Wrong prediction kept.");
  AST_DATA_NOPRED: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE5]
    acc_req && !acc_istr && !acc_we && acc_done |-> !ibuf_use && cif.ready) else $error("Data read predicted.");
  AST_INC_REG: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE10]
    st_ff == S_DECODE && adv && is_inc && dmode == MODE_REG |=> st_ff == S_FETCH && instr_done) else $error("Register increment slow.");
  AST_INC_SAME: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE11]
    st_ff == S_WR && is_inc && acc_req |-> acc_addr == rd_addr_ff) else $error("Increment wrote elsewhere.");
  AST_COPY_ORDER: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE13]
    st_ff == S_OPRD |-> dst_ph_ff || !is_copy) else $error("Copy read before destination address.");
  AST_FETCH_FIRST: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE9]
    instr_done |-> st_ff == S_FETCH) else $error("Instruction did not return to fetch.");
  COV_COPY: cover property (@(posedge sys_clk) disable iff (!resetn) st_ff == S_WR && adv && is_copy);
  COV_INC_MEM: cover property (@(posedge sys_clk) disable iff (!resetn) st_ff == S_WR && adv && is_inc);
  COV_IBUF: cover property (@(posedge sys_clk) disable iff (!resetn) ibuf_use);
endmodule

/* test_cpu_memory_access_path.sv */
// Self-checking bench for the processor memory access path.
`timescale 1ns/100ps
module test_cpu_memory_access_path import cmap_pkg::*; ;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic dma_busy = 1'b0;
  logic dma_wr = 1'b0;
  logic [ADDR_W-1:0] dma_addr = 16'h0000;
  logic mem_req, mem_we, mem_ack, instr_done, cpu_stall;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata, mem_rdata, pc_value;
  int mismatches = 0;
  int num_checks = 0;
  int n_done = 0;
  int req_in_dma = 0;
  int cyc = 0;
  int last = 0;
  int gap = 0;
  // Operands sit at a cache index that no program line uses, so fetches never evict them.
  logic [15:0] prog [10] = '{16'h0a80, 16'h0a9f, 16'h0120, 16'h101f, 16'h0122,
                             16'h17df, 16'h0120, 16'h0124, 16'h15c7, 16'h0000};

  cmap_top u_dut (.sys_clk, .resetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .dma_busy, .dma_wr, .dma_addr, .instr_done, .cpu_stall, .pc_value);
  cmap_mem_model u_mem (.sys_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  initial forever #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dma_busy && mem_req !== 1'b0) req_in_dma <= req_in_dma + 1;
    if (instr_done === 1'b1) begin
      n_done <= n_done + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int i);
    if (i >= 5000) begin
      mismatches++;
      $display("[ERR] %0t wait expired", $time);
      end_sim();
    end
    @(posedge sys_clk);
  endtask

  function automatic int reads_of(input logic [15:0] a);
    int n;
    n = 0;
    foreach (u_mem.rd_log[k]) if (u_mem.rd_log[k] === a) n++;
    return n;
  endfunction

  // Waits for the three writes of loop pass k and compares them.
  task automatic check_pass(input int k, input logic [15:0] v);
    int i;
    int j;
    j = 3 * (k - 1);
    for (i = 0; u_mem.wa_log.size() < j + 3; i++) tick(i);
    check(u_mem.wa_log[j], 16'h0120);
    check(u_mem.wd_log[j], v);
    check(u_mem.wa_log[j+1], 16'h0122);
    check(u_mem.wd_log[j+1], 16'(k));
    check(u_mem.wa_log[j+2], 16'h0124);
    check(u_mem.wd_log[j+2], v);
  endtask

  // Takes the bus for the DMA side once the path has no cycle on it.
  task automatic grab_bus(input int hold, input logic wr);
    int i;
    for (i = 0; mem_req !== 1'b0; i++) tick(i);
    dma_busy <= 1'b1;
    dma_wr <= wr;
    dma_addr <= 16'h0120;
    if (wr) u_mem.mem[8'h90] <= 16'h2000;
    repeat (hold) @(posedge sys_clk);
    dma_busy <= 1'b0;
    dma_wr <= 1'b0;
  endtask

  task automatic t_reset();
    int i;
    u_mem.lat = 2;
    foreach (prog[k]) u_mem.mem[k] = prog[k];
    u_mem.mem[8'h90] = 16'h1234;
    repeat (10) @(posedge sys_clk);
    check(16'(mem_req), 16'h0000);
    check(16'(instr_done), 16'h0000);
    check(16'(cpu_stall), 16'h0001);
    check(pc_value, RESET_PC);
    resetn <= 1'b1;
    for (i = 0; u_mem.rd_log.size() < 2; i++) tick(i);
    check(u_mem.rd_log[0], RESET_PC);
    check(u_mem.rd_log[1], RESET_PC + WORD_STEP);
  endtask

  task automatic t_pairs();
    int i;
    for (i = 0; i + 1 < u_mem.rd_log.size(); i += 2) begin
      check(u_mem.rd_log[i] & 16'h0003, 16'h0000);
      check(u_mem.rd_log[i+1], u_mem.rd_log[i] + WORD_STEP);
    end
  endtask

  task automatic t_branch();
    int i;
    for (i = 0; n_done < 5; i++) tick(i);
    check(pc_value & 16'hfffc, 16'h0000);
  endtask

  task automatic t_hit();
    int n;
    u_mem.lat = 0;
    n = reads_of(16'h0120);
    check_pass(2, 16'h1236);
    check(16'(reads_of(16'h0120)), 16'(n));
    check(16'(gap % UCYC_CYCLES), 16'h0000);
  endtask

  task automatic t_dma();
    grab_bus(60, 1'b0);
    check_pass(3, 16'h1237);
    check(16'(req_in_dma), 16'h0000);
  endtask

  task automatic t_snoop();
    int n;
    n = reads_of(16'h0120);
    grab_bus(1, 1'b1);
    check_pass(4, 16'h2001);
    check(16'(reads_of(16'h0120)), 16'(n + 1));
  endtask

  initial begin
    t_reset();
    check_pass(1, 16'h1235);
    t_branch();
    t_hit();
    t_dma();
    t_snoop();
    t_pairs();
    end_sim();
  end
endmodule
